/* File: hdl/idx_exec_pkg.sv */
// constants and types shared by the indexed byte and bit execution block
package idx_exec_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int INSTR_W = 16;
  localparam int FLAG_W = 5;

  // instruction field positions
  localparam int OPC_ADD_LSB = 10;
  localparam int OPC_BSF_LSB = 12;
  localparam int OPC_INDEXED_SET_ALL_ONES_LSB = 9;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam int BITNUM_LSB = 9;

  // opcode patterns
  localparam logic [5:0] OPC_ADD = 6'h09;
  localparam logic [3:0] OPC_BSF = 4'h8;
  localparam logic [6:0] OPC_INDEXED_SET_ALL_ONES = 7'h34;

  // addressing constants
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [7:0] ALL_ONES = 8'hff;

  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;

  // reset values
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [15:0] INSTR_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_READ = 3'b010,
    ST_PROC = 3'b011,
    ST_WRITE = 3'b100
  } exec_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ADD = 2'b01,
    OP_BSF = 2'b10,
    OP_INDEXED_SET_ALL_ONES = 2'b11
  } exec_op_t;
endpackage

/* File: hdl/operand_addr_gen.sv */
// effective data address from an operand field
`timescale 1ns/100ps
module operand_addr_gen (
  input wire logic ext_en_i,
  input wire logic access_i,
  input wire logic [7:0] operand_i,
  input wire logic [idx_exec_pkg::ADDR_W-1:0] frame_pointer_reg_i,
  input wire logic [idx_exec_pkg::BANK_W-1:0] bank_select_register_i,
  output logic [idx_exec_pkg::ADDR_W-1:0] addr_o,
  output logic indexed_o
);
  import idx_exec_pkg::*;

  always_comb begin
    indexed_o = ext_en_i && !access_i && (operand_i <= INDEX_LIMIT);
    if (indexed_o) begin
      addr_o = frame_pointer_reg_i + {4'h0, operand_i};
    end else if (access_i) begin
      addr_o = {bank_select_register_i, operand_i};
    end else if (operand_i < ACCESS_SPLIT) begin
      addr_o = {ACCESS_LOW_BANK, operand_i};
    end else begin
      addr_o = {ACCESS_HIGH_BANK, operand_i};
    end
  end
endmodule

/* File: hdl/indexed_offset_byte_bit_exec.sv */
// executor for byte and bit operations with indexed literal offset addressing
`timescale 1ns/100ps
module indexed_offset_byte_bit_exec (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic extended_set_enable_bit_i,
  input wire logic instr_valid_i,
  input wire logic [idx_exec_pkg::INSTR_W-1:0] instr_i,
  input wire logic [idx_exec_pkg::ADDR_W-1:0] frame_pointer_reg_i,
  input wire logic [idx_exec_pkg::BANK_W-1:0] bank_select_register_i,
  input wire logic [idx_exec_pkg::DATA_W-1:0] mem_rdata_i,
  output logic ready_o,
  output logic done_o,
  output logic unsupported_o,
  output logic indexed_o,
  output logic ext_active_o,
  output logic [idx_exec_pkg::DATA_W-1:0] w_o,
  output logic [idx_exec_pkg::FLAG_W-1:0] status_o,
  output logic [idx_exec_pkg::ADDR_W-1:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [idx_exec_pkg::DATA_W-1:0] mem_wdata_o
);
  import idx_exec_pkg::*;

  // all block state
  typedef struct packed {
    exec_state_t st;
    logic loaded;
    logic ext_en;
    logic [INSTR_W-1:0] instr;
    exec_op_t op;
    logic [DATA_W-1:0] w;
    logic [FLAG_W-1:0] flags;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [DATA_W-1:0] wdata;
    logic ready;
    logic done;
    logic unsup;
    logic indexed;
  } exec_regs_t;

  // cleared state
  localparam exec_regs_t REGS_RESET = '{
    st: ST_IDLE,
    loaded: 1'b0,
    ext_en: 1'b0,
    instr: INSTR_RESET,
    op: OP_NONE,
    w: W_RESET,
    flags: FLAGS_RESET,
    addr: ADDR_RESET,
    rd: 1'b0,
    wr: 1'b0,
    wdata: 8'h00,
    ready: 1'b0,
    done: 1'b0,
    unsup: 1'b0,
    indexed: 1'b0
  };

  exec_regs_t cur;
  exec_regs_t next_cur;
  logic [ADDR_W-1:0] gen_addr;
  logic gen_indexed;
  exec_op_t dec_op;
  logic [8:0] sum;
  logic [4:0] low_sum;
  wire logic [DATA_W-1:0] bit_mask;
  logic [FLAG_W-1:0] add_flags;
  logic [2:0] bit_num;
  logic dest_mem;

  operand_addr_gen u_addr (
    .ext_en_i(cur.ext_en),
    .access_i(cur.instr[ACCESS_BIT]),
    .operand_i(cur.instr[7:0]),
    .frame_pointer_reg_i(frame_pointer_reg_i),
    .bank_select_register_i(bank_select_register_i),
    .addr_o(gen_addr),
    .indexed_o(gen_indexed)
  );

  // opcode decode
  always_comb begin
    dec_op = OP_NONE;
    if (cur.instr[INSTR_W-1:OPC_ADD_LSB] == OPC_ADD) begin
      dec_op = OP_ADD;
    end else if (cur.instr[INSTR_W-1:OPC_BSF_LSB] == OPC_BSF) begin
      dec_op = OP_BSF;
    end else if (cur.instr[INSTR_W-1:OPC_INDEXED_SET_ALL_ONES_LSB] == OPC_INDEXED_SET_ALL_ONES) begin
      dec_op = OP_INDEXED_SET_ALL_ONES;
    end
  end

  // arithmetic and bit helpers
  always_comb begin
    sum = {1'b0, cur.w} + {1'b0, mem_rdata_i};
    low_sum = {1'b0, cur.w[3:0]} + {1'b0, mem_rdata_i[3:0]};
    bit_num = cur.instr[BITNUM_LSB+2:BITNUM_LSB];
    dest_mem = cur.instr[DEST_BIT];
    add_flags[FLAG_C] = sum[8];
    add_flags[FLAG_DC] = low_sum[4];
    add_flags[FLAG_Z] = (sum[7:0] == 8'h00);
    add_flags[FLAG_OV] = (cur.w[7] == mem_rdata_i[7]) && (sum[7] != cur.w[7]);
    add_flags[FLAG_N] = sum[7];
  end

  // one-hot mask of the bit to force
  for (genvar i = 0; i < DATA_W; i++) begin : g_mask
    assign bit_mask[i] = (bit_num == 3'(i));
  end

  // instruction sequencer
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    case (cur.st)
      ST_IDLE: begin
        if (!cur.loaded) begin
          next_cur.ext_en = extended_set_enable_bit_i;
          next_cur.loaded = 1'b1;
          next_cur.ready = 1'b1;
        end else if (instr_valid_i) begin
          next_cur.instr = instr_i;
          next_cur.ready = 1'b0;
          next_cur.unsup = 1'b0;
          next_cur.st = ST_DECODE;
        end
      end
      ST_DECODE: begin
        next_cur.op = dec_op;
        next_cur.addr = gen_addr;
        next_cur.indexed = gen_indexed;
        if (dec_op == OP_NONE) begin
          next_cur.unsup = 1'b1;
          next_cur.st = ST_WRITE;
        end else begin
          next_cur.rd = (dec_op != OP_INDEXED_SET_ALL_ONES);
          next_cur.st = ST_READ;
        end
      end
      ST_READ: begin
        next_cur.rd = 1'b0;
        next_cur.st = ST_PROC;
      end
      ST_PROC: begin
        next_cur.st = ST_WRITE;
        case (cur.op)
          OP_ADD: begin
            next_cur.flags = add_flags;
            if (dest_mem) begin
              next_cur.wdata = sum[7:0];
              next_cur.wr = 1'b1;
            end else begin
              next_cur.w = sum[7:0];
            end
          end
          OP_BSF: begin
            next_cur.wdata = mem_rdata_i | bit_mask;
            next_cur.wr = 1'b1;
          end
          OP_INDEXED_SET_ALL_ONES: begin
            next_cur.wdata = ALL_ONES;
            next_cur.wr = 1'b1;
          end
          default: begin
            next_cur.wr = 1'b0;
          end
        endcase
      end
      ST_WRITE: begin
        next_cur.wr = 1'b0;
        next_cur.done = 1'b1;
        next_cur.ready = 1'b1;
        next_cur.st = ST_IDLE;
      end
      default: begin
        next_cur = REGS_RESET;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur <= REGS_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // output drive
  always_comb begin
    ready_o = cur.ready;
    done_o = cur.done;
    unsupported_o = cur.unsup;
    indexed_o = cur.indexed;
    ext_active_o = cur.ext_en;
    w_o = cur.w;
    status_o = cur.flags;
    mem_addr_o = cur.addr;
    mem_rd_o = cur.rd;
    mem_wr_o = cur.wr;
    mem_wdata_o = cur.wdata;
  end
endmodule

/* File: tb/idx_exec_assertions.sv */
// checker for the indexed execution block
`timescale 1ns/100ps
module idx_exec_chk
  import idx_exec_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic instr_valid_i,
  input wire logic ready_o,
  input wire logic done_o,
  input wire logic indexed_o,
  input wire logic ext_active_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic [ADDR_W-1:0] frame_pointer_reg_i,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [BANK_W-1:0] bank_select_register_i,
  input wire logic [FLAG_W-1:0] status_o,
  input wire logic [DATA_W-1:0] mem_wdata_o
);
  logic [15:0] li;
  logic [11:0] fp;
  logic [3:0] bs;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      li <= '0;
      fp <= '0;
      bs <= '0;
    end else if (ready_o && instr_valid_i) begin
      li <= instr_i;
      fp <= frame_pointer_reg_i;
      bs <= bank_select_register_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence add_taken;
    ready_o && instr_valid_i && instr_i[15:10] == OPC_ADD;
  endsequence
  sequence keep_taken;
    ready_o && instr_valid_i && (instr_i[15:12] == OPC_BSF || instr_i[15:9] == OPC_INDEXED_SET_ALL_ONES);
  endsequence
  add_done_a: assert property (add_taken |-> ##[3:5] done_o) else $error("add late");
  add_dest_a: assert property (add_taken ##0 !instr_i[DEST_BIT] |-> ##1 !mem_wr_o [*5])
    else $error("add wrote memory");
  flags_kept_a: assert property (keep_taken |-> ##1 $stable(status_o) [*5]) else $error("flags moved");
  setall_data_a: assert property (mem_wr_o && li[15:9] == OPC_INDEXED_SET_ALL_ONES |-> mem_wdata_o == ALL_ONES)
    else $error("set-all data");
  bitset_data_a: assert property (mem_wr_o && li[15:12] == OPC_BSF |-> mem_wdata_o[li[11:9]])
    else $error("bit-set data");
  index_addr_a: assert property (mem_rd_o && indexed_o |-> mem_addr_o == fp + 12'(li[7:0]))
    else $error("indexed address");
  index_cond_a: assert property (mem_rd_o |-> indexed_o == (ext_active_o && !li[ACCESS_BIT]
    && li[7:0] <= INDEX_LIMIT)) else $error("indexed choice");
  bank_addr_a: assert property (mem_rd_o && li[ACCESS_BIT] |-> mem_addr_o == {bs, li[7:0]})
    else $error("bank address");
  index_write_a: assert property (mem_wr_o && indexed_o |-> mem_addr_o == fp + 12'(li[7:0]))
    else $error("indexed write address");
  status_src_a: assert property ($changed(status_o) |-> li[15:10] == OPC_ADD)
    else $error("flags moved off add");
endmodule
bind indexed_offset_byte_bit_exec idx_exec_chk chk (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .instr_valid_i(instr_valid_i),
  .ready_o(ready_o),
  .done_o(done_o),
  .indexed_o(indexed_o),
  .ext_active_o(ext_active_o),
  .mem_rd_o(mem_rd_o),
  .mem_wr_o(mem_wr_o),
  .instr_i(instr_i),
  .frame_pointer_reg_i(frame_pointer_reg_i),
  .mem_addr_o(mem_addr_o),
  .bank_select_register_i(bank_select_register_i),
  .status_o(status_o),
  .mem_wdata_o(mem_wdata_o)
);

/* File: tb/test_indexed_offset_byte_bit_exec.sv */
// self-checking bench for the indexed execution block
`timescale 1ns/100ps
module test_indexed_offset_byte_bit_exec;
  import idx_exec_pkg::*;
  logic clk_i, reset_i, extended_set_enable_bit_i, instr_valid_i, ready_o, done_o;
  logic unsupported_o, indexed_o, ext_active_o, mem_rd_o, mem_wr_o;
  logic [15:0] instr_i;
  logic [11:0] frame_pointer_reg_i, mem_addr_o;
  logic [3:0] bank_select_register_i;
  logic [7:0] mem_rdata_i, w_o, mem_wdata_o;
  logic [4:0] status_o;
  logic [7:0] mem [4096];
  int err_total, samples_checked;
  indexed_offset_byte_bit_exec dut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .extended_set_enable_bit_i(extended_set_enable_bit_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .frame_pointer_reg_i(frame_pointer_reg_i),
    .bank_select_register_i(bank_select_register_i),
    .mem_rdata_i(mem_rdata_i),
    .ready_o(ready_o),
    .done_o(done_o),
    .unsupported_o(unsupported_o),
    .indexed_o(indexed_o),
    .ext_active_o(ext_active_o),
    .w_o(w_o),
    .status_o(status_o),
    .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o)
  );
  assign mem_rdata_i = mem[mem_addr_o];
  always @(posedge clk_i) if (mem_wr_o) mem[mem_addr_o] <= mem_wdata_o;
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [11:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic await(input bit for_done);
    int n = 0;
    while ((for_done ? done_o : ready_o) !== 1'b1) begin
      @(posedge clk_i);
      #1;
      if (++n > 40) begin
        err_total++;
        test_done();
      end
    end
  endtask
  task automatic start(input logic en);
    reset_i = 1'b1;
    extended_set_enable_bit_i = en;
    repeat (16) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
  endtask
  task automatic exec(input logic [15:0] ins);
    await(1'b0);
    instr_i = ins;
    instr_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
    instr_valid_i = 1'b0;
    await(1'b1);
  endtask
  task automatic t_add();
    frame_pointer_reg_i = 12'ha00;
    mem[12'ha2c] = 8'h20;
    mem[12'ha05] = 8'he0;
    mem[12'ha07] = 8'h7f;
    exec(16'h242c);
    chk("w", w_o, 8'h20);
    exec(16'h262c);
    chk("mem", mem[12'ha2c], 8'h40);
    chk("w", w_o, 8'h20);
    exec(16'h2405);
    chk("status", status_o, 5'h05);
    exec(16'h2407);
    exec(16'h2407);
    chk("w", w_o, 8'hfe);
    chk("status", status_o, 5'h1a);
    $display("add test end");
  endtask
  task automatic t_bsf();
    mem[12'ha0a] = 8'h55;
    mem[12'ha10] = 8'h00;
    exec(16'h8e0a);
    chk("mem", mem[12'ha0a], 8'hd5);
    for (int b = 0; b < 8; b++) exec({4'h8, 3'(b), 1'b0, 8'h10});
    chk("mem", mem[12'ha10], 8'hff);
    chk("status", status_o, 5'h1a);
    chk("indexed", indexed_o, 1'b1);
    $display("bit-set test end");
  endtask
  task automatic t_indexed_set_all_ones();
    frame_pointer_reg_i = 12'hffa;
    mem[12'h059] = 8'h00;
    mem[12'h060] = 8'h00;
    exec(16'h685f);
    chk("mem", mem[12'h059], 8'hff);
    chk("status", status_o, 5'h1a);
    exec(16'h6860);
    chk("mem", mem[12'h060], 8'hff);
    chk("indexed", indexed_o, 1'b0);
    mem[12'h050] = 8'h00;
    exec(16'h6950);
    chk("mem", mem[12'h050], 8'hff);
    chk("indexed", indexed_o, 1'b0);
    $display("set-all test end");
  endtask
  task automatic t_off();
    frame_pointer_reg_i = 12'ha00;
    bank_select_register_i = 4'h3;
    mem[12'h02c] = 8'h00;
    mem[12'h310] = 8'h00;
    mem[12'hf90] = 8'h00;
    exec(16'h682c);
    chk("mem", mem[12'h02c], 8'hff);
    chk("active", ext_active_o, 1'b0);
    exec(16'h8110);
    chk("mem", mem[12'h310], 8'h01);
    exec(16'h2510);
    chk("w", w_o, 8'h01);
    exec(16'hffff);
    chk("unsupported", unsupported_o, 1'b1);
    chk("w", w_o, 8'h01);
    exec(16'h6890);
    chk("mem", mem[12'hf90], 8'hff);
    chk("unsupported", unsupported_o, 1'b0);
    $display("disabled test end");
  endtask
  initial begin
    err_total = 0;
    samples_checked = 0;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    frame_pointer_reg_i = 12'h000;
    bank_select_register_i = 4'h0;
    start(1'b1);
    t_add();
    t_bsf();
    t_indexed_set_all_ones();
    start(1'b0);
    t_off();
    test_done();
  end
endmodule
